/* File: core/tcsf_pkg.sv */
// Overview of operation
// - bit 7 phase align on, bit 6 slide
// - compat direction bit: 0 monitor, 1 drive
// - fallback may take over compat direction
// - selector invert bit flips main selector output
// - four-bit main source field decode
// - pairing bit makes local codes synchronized pairs
// - netref output enable field routes references
// - dejitter bypass and netref invert bits
// - netref source field decode
// - framer clock select, 000 is high impedance
// - input sync interpretation: 4 or 8 MHz
// - pair outputs enabled, auto-off on failure
// - bus clock rate: inverted 4M or 8M
// - compat frame width narrow or wide
// - pll1 input field decode
// - pll bypass and rate multipliers
// - compat output rate, 00 high impedance
// - fallback resource field replaces pll1 input
// - fallback mode field decode
// - force fallback uses secondary resources immediately
// - fallback source field decode
// - general mode: local selections never trigger
// - fallback is sticky until software rewrites the secondary register
package tcsf_pkg;
   // register word indices; byte address is four times these
   localparam logic [2:0] TCSF_IDX_MAIN = 3'h0;
   localparam logic [2:0] TCSF_IDX_NETREF = 3'h1;
   localparam logic [2:0] TCSF_IDX_PROG = 3'h2;
   localparam logic [2:0] TCSF_IDX_RES = 3'h3;
   localparam logic [2:0] TCSF_IDX_SEC = 3'h4;
   localparam logic [2:0] TCSF_IDX_MASK = 3'h5;
   localparam logic [2:0] TCSF_IDX_CTRL = 3'h6;
   localparam logic [2:0] TCSF_IDX_STATUS = 3'h7;
   localparam logic [7:0] TCSF_REG_RESET = 8'h00;
   localparam logic [1:0] TCSF_WORD_LSB = 2'h0;
   // main source codes
   localparam logic [3:0] TCSF_SRC_OSC = 4'h0;
   localparam logic [3:0] TCSF_SRC_NETREF = 4'h1;
   localparam logic [3:0] TCSF_SRC_PAIR_A = 4'h2;
   localparam logic [3:0] TCSF_SRC_PAIR_B = 4'h3;
   localparam logic [3:0] TCSF_SRC_C4 = 4'h4;
   localparam logic [3:0] TCSF_SRC_C16 = 4'h5;
   localparam logic [3:0] TCSF_SRC_SC2 = 4'h6;
   localparam logic [3:0] TCSF_SRC_SC48 = 4'h7;
   localparam logic [3:0] TCSF_SRC_LOCAL = 4'h8;
   // fallback modes and sources
   localparam logic [1:0] TCSF_FB_OSC4 = 2'h0;
   localparam logic [1:0] TCSF_FB_OFF = 2'h1;
   localparam logic [1:0] TCSF_FB_GENERAL = 2'h2;
   localparam logic [1:0] TCSF_FB_H100 = 2'h3;
   localparam logic [2:0] TCSF_FBS_NETREF2 = 3'h1;
   localparam logic [2:0] TCSF_FBS_NETREF1 = 3'h4;
   localparam logic [2:0] TCSF_FBS_LOCAL1 = 3'h5;
   // failure input positions
   localparam int TCSF_FAIL_W = 6;
   localparam int TCSF_F_NETREF = 0;
   localparam int TCSF_F_A = 1;
   localparam int TCSF_F_B = 2;
   localparam int TCSF_F_C4C2 = 3;
   localparam int TCSF_F_C16 = 4;
   localparam int TCSF_F_CFRAME = 5;
   // pll multipliers and high impedance codes
   localparam logic [5:0] TCSF_P1_MUL_LO = 6'h10;
   localparam logic [5:0] TCSF_P1_MUL_HI = 6'h20;
   localparam logic [5:0] TCSF_P2_MUL_LO = 6'h08;
   localparam logic [5:0] TCSF_P2_MUL_HI = 6'h10;
   localparam logic [2:0] TCSF_FRAMER_HIZ = 3'h0;
   localparam logic [1:0] TCSF_COMPAT_HIZ = 2'h0;

   typedef struct packed {
      logic phase_align_enable;
      logic phase_align_style;
      logic compat_direction;
      logic selector_invert;
      logic [3:0] main_source_field;
   } tcsf_main_s;
   typedef struct packed {
      logic [1:0] netref_output_enable;
      logic dejitter_bypass;
      logic netref_invert;
      logic [3:0] netref_source_field;
   } tcsf_netref_s;
   typedef struct packed {
      logic [2:0] framer_clock_select;
      logic input_sync_interpretation;
      logic pair_a_output_enable;
      logic pair_b_output_enable;
      logic bus_clock_rate;
      logic compat_frame_width;
   } tcsf_prog_s;
   typedef struct packed {
      logic [1:0] pll1_input_field;
      logic pll1_bypass;
      logic pll1_rate;
      logic pll2_bypass;
      logic pll2_rate;
      logic [1:0] compat_output_rate;
   } tcsf_res_s;
   typedef struct packed {
      logic [1:0] fallback_resource_field;
      logic [1:0] fallback_mode_field;
      logic force_fallback;
      logic [2:0] fallback_source_field;
   } tcsf_sec_s;
   typedef struct packed {
      logic reserved;
      logic unused_6;
      logic netref_pick2;
      logic local_pairing;
      logic [3:0] unused_lo;
   } tcsf_ctrl_reg_s;
   typedef enum logic {TCSF_NORMAL, TCSF_FALLEN} tcsf_fb_e;

   // decoded clock controls toward the clock tree
   typedef struct packed {
      logic phase_align_enable;
      logic phase_align_style;
      logic compat_master;
      logic selector_invert;
      logic [3:0] main_source;
      logic osc_div4_select;
      logic local_pairs;
      logic netref_pick2;
      logic [1:0] netref_output_enable;
      logic dejitter_bypass;
      logic netref_invert;
      logic [3:0] netref_source;
      logic [2:0] framer_clock_select;
      logic framer_clock_oe_n;
      logic input_sync_interpretation;
      logic pair_a_drive;
      logic pair_b_drive;
      logic bus_clock_rate;
      logic compat_frame_width;
      logic [1:0] pll1_input;
      logic pll1_bypass;
      logic [5:0] pll1_mult;
      logic pll2_bypass;
      logic [5:0] pll2_mult;
      logic [1:0] compat_output_rate;
      logic compat_outputs_oe_n;
      logic fallback_active;
   } tcsf_ctrl_s;
endpackage

/* File: core/tcsf_clock_regs.sv */
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module tcsf_clock_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [tcsf_pkg::TCSF_FAIL_W-1:0] clock_fail,
   output tcsf_pkg::tcsf_ctrl_s ctrl
);
   // register storage
   tcsf_pkg::tcsf_main_s main_r; // main source select
   tcsf_pkg::tcsf_netref_s netref_r; // network reference select
   tcsf_pkg::tcsf_prog_s prog_r; // programmable outputs
   tcsf_pkg::tcsf_res_s res_r; // resource select
   tcsf_pkg::tcsf_sec_s sec_r; // secondary fallback select
   logic [7:0] mask_r; // watchdog mask
   tcsf_pkg::tcsf_ctrl_reg_s gen_r; // general control
   // fallback and auto-disable state
   tcsf_pkg::tcsf_fb_e fb_state;
   logic dis_a; // pair a removed after its failure
   logic dis_b; // pair b removed after its failure
   logic ovr_valid; // fallback took over compat direction
   logic ovr_master; // direction chosen by fallback
   // bus decode
   logic [2:0] idx;
   logic mapped;
   logic setup;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   // fallback decode
   logic [tcsf_pkg::TCSF_FAIL_W-1:0] need;
   logic [tcsf_pkg::TCSF_FAIL_W-1:0] seen;
   logic trigger;
   logic fb_active;
   tcsf_pkg::tcsf_ctrl_s next_ctrl;

   assign idx = paddr[4:2];
   // upper address bits and byte offset must be zero
   assign mapped = (paddr[7:5] == 3'h0) && (paddr[1:0] == tcsf_pkg::TCSF_WORD_LSB);
   assign setup = psel & ~penable;
   // write lands at the completing edge of the access phase
   assign wr_en = psel & penable & pready & pwrite & mapped & pstrb[0];
   assign wbyte = pwdata[7:0];

   // read mux; status shows the block's own fallback state
   always_comb begin
      unique case (idx)
         tcsf_pkg::TCSF_IDX_MAIN: rd_byte = main_r;
         tcsf_pkg::TCSF_IDX_NETREF: rd_byte = netref_r;
         tcsf_pkg::TCSF_IDX_PROG: rd_byte = prog_r;
         tcsf_pkg::TCSF_IDX_RES: rd_byte = res_r;
         tcsf_pkg::TCSF_IDX_SEC: rd_byte = sec_r;
         tcsf_pkg::TCSF_IDX_MASK: rd_byte = mask_r;
         tcsf_pkg::TCSF_IDX_CTRL: rd_byte = gen_r;
         tcsf_pkg::TCSF_IDX_STATUS:
            rd_byte = {3'h0, ctrl.compat_master, ovr_valid, dis_b, dis_a,
                       fb_state == tcsf_pkg::TCSF_FALLEN};
      endcase
   end

   // apb answer: one setup, one access cycle, no extra waits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         // unmapped words answer with an error; status ignores writes
         pslverr <= setup & ~mapped;
         if (setup && !pwrite && mapped) begin
            prdata <= {24'h00_0000, rd_byte};
         end else if (setup) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // software clock registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_r <= tcsf_pkg::TCSF_REG_RESET;
         netref_r <= tcsf_pkg::TCSF_REG_RESET;
         prog_r <= tcsf_pkg::TCSF_REG_RESET;
         res_r <= tcsf_pkg::TCSF_REG_RESET;
         sec_r <= tcsf_pkg::TCSF_REG_RESET;
         mask_r <= tcsf_pkg::TCSF_REG_RESET;
         gen_r <= tcsf_pkg::TCSF_REG_RESET;
      end else if (wr_en) begin
         unique case (idx)
            tcsf_pkg::TCSF_IDX_MAIN: main_r <= wbyte;
            tcsf_pkg::TCSF_IDX_NETREF: netref_r <= wbyte;
            tcsf_pkg::TCSF_IDX_PROG: prog_r <= wbyte;
            tcsf_pkg::TCSF_IDX_RES: res_r <= wbyte;
            tcsf_pkg::TCSF_IDX_SEC: sec_r <= wbyte;
            tcsf_pkg::TCSF_IDX_MASK: mask_r <= wbyte;
            // reserved top bit of general control stays zero
            tcsf_pkg::TCSF_IDX_CTRL: gen_r <= {1'b0, wbyte[6:0]};
            tcsf_pkg::TCSF_IDX_STATUS: ;
         endcase
      end
   end

   // which failure lines make up the present main selection
   always_comb begin
      need = '0;
      unique case (main_r.main_source_field)
         tcsf_pkg::TCSF_SRC_NETREF: need[tcsf_pkg::TCSF_F_NETREF] = 1'b1;
         tcsf_pkg::TCSF_SRC_PAIR_A: need[tcsf_pkg::TCSF_F_A] = 1'b1;
         tcsf_pkg::TCSF_SRC_PAIR_B: need[tcsf_pkg::TCSF_F_B] = 1'b1;
         tcsf_pkg::TCSF_SRC_C4: begin
            need[tcsf_pkg::TCSF_F_C4C2] = 1'b1;
            need[tcsf_pkg::TCSF_F_CFRAME] = 1'b1;
         end
         tcsf_pkg::TCSF_SRC_C16: begin
            need[tcsf_pkg::TCSF_F_C4C2] = 1'b1;
            need[tcsf_pkg::TCSF_F_C16] = 1'b1;
            need[tcsf_pkg::TCSF_F_CFRAME] = 1'b1;
         end
         tcsf_pkg::TCSF_SRC_SC2, tcsf_pkg::TCSF_SRC_SC48:
            need[tcsf_pkg::TCSF_F_CFRAME] = 1'b1;
         // oscillator and local references carry no watchdog here
         default: need = '0;
      endcase
   end

   // only unmasked failures count toward fallback; pair auto-disable uses clock_fail unmasked
   assign seen = clock_fail & mask_r[tcsf_pkg::TCSF_FAIL_W-1:0];

   // trigger per fallback mode; one fallback only
   always_comb begin
      unique case (sec_r.fallback_mode_field)
         tcsf_pkg::TCSF_FB_OFF: trigger = 1'b0;
         tcsf_pkg::TCSF_FB_H100:
            trigger = seen[tcsf_pkg::TCSF_F_A] | seen[tcsf_pkg::TCSF_F_B];
         default: trigger = |(seen & need);
      endcase
      if (fb_state == tcsf_pkg::TCSF_FALLEN) begin
         trigger = 1'b0;
      end
   end

   assign fb_active = (fb_state == tcsf_pkg::TCSF_FALLEN) | sec_r.force_fallback;

   // sticky fallback; rewriting the secondary register re-arms it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fb_state <= tcsf_pkg::TCSF_NORMAL;
      end else begin
         unique case (fb_state)
            tcsf_pkg::TCSF_NORMAL:
               if (trigger) begin
                  fb_state <= tcsf_pkg::TCSF_FALLEN;
               end
            tcsf_pkg::TCSF_FALLEN:
               // a new failure never re-enters; only software re-arms
               if (wr_en && idx == tcsf_pkg::TCSF_IDX_SEC) begin
                  fb_state <= tcsf_pkg::TCSF_NORMAL;
               end
         endcase
      end
   end

   // compat direction takeover in h.100 mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_valid <= 1'b0;
         ovr_master <= 1'b0;
      end else if (trigger && sec_r.fallback_mode_field == tcsf_pkg::TCSF_FB_H100) begin
         if (main_r.compat_direction) begin
            // a master that lost its own set steps off the bus
            if ((prog_r.pair_a_output_enable && seen[tcsf_pkg::TCSF_F_A]) ||
                (prog_r.pair_b_output_enable && seen[tcsf_pkg::TCSF_F_B])) begin
               ovr_valid <= 1'b1;
               ovr_master <= 1'b0;
            end
         end else if ((main_r.main_source_field == tcsf_pkg::TCSF_SRC_PAIR_A &&
                       prog_r.pair_b_output_enable && seen[tcsf_pkg::TCSF_F_A]) ||
                      (main_r.main_source_field == tcsf_pkg::TCSF_SRC_PAIR_B &&
                       prog_r.pair_a_output_enable && seen[tcsf_pkg::TCSF_F_B])) begin
            // slave driving the other set becomes compat master
            ovr_valid <= 1'b1;
            ovr_master <= 1'b1;
         end
      end else if (wr_en && (idx == tcsf_pkg::TCSF_IDX_MAIN || idx == tcsf_pkg::TCSF_IDX_SEC)) begin
         // software rewriting direction takes control back
         ovr_valid <= 1'b0;
      end
   end

   // pair auto-disable; the failure wins over a same-cycle rewrite
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dis_a <= 1'b0;
         dis_b <= 1'b0;
      end else begin
         if (clock_fail[tcsf_pkg::TCSF_F_A] && prog_r.pair_a_output_enable) begin
            dis_a <= 1'b1;
         end else if (wr_en && idx == tcsf_pkg::TCSF_IDX_PROG) begin
            dis_a <= 1'b0;
         end
         if (clock_fail[tcsf_pkg::TCSF_F_B] && prog_r.pair_b_output_enable) begin
            dis_b <= 1'b1;
         end else if (wr_en && idx == tcsf_pkg::TCSF_IDX_PROG) begin
            dis_b <= 1'b0;
         end
      end
   end

   // decode the registers into clock tree controls
   always_comb begin
      next_ctrl = '0;
      next_ctrl.phase_align_enable = main_r.phase_align_enable;
      next_ctrl.phase_align_style = main_r.phase_align_style;
      next_ctrl.compat_master = ovr_valid ? ovr_master : main_r.compat_direction;
      next_ctrl.selector_invert = main_r.selector_invert;
      next_ctrl.main_source = main_r.main_source_field;
      next_ctrl.local_pairs = gen_r.local_pairing;
      next_ctrl.netref_pick2 = gen_r.netref_pick2;
      if (fb_active) begin
         // secondary source is a subset of the main choices
         next_ctrl.osc_div4_select = 1'b0;
         if (sec_r.fallback_source_field == tcsf_pkg::TCSF_FBS_NETREF2) begin
            next_ctrl.main_source = tcsf_pkg::TCSF_SRC_NETREF;
            next_ctrl.netref_pick2 = 1'b1;
         end else if (sec_r.fallback_source_field == tcsf_pkg::TCSF_FBS_NETREF1) begin
            next_ctrl.main_source = tcsf_pkg::TCSF_SRC_NETREF;
            next_ctrl.netref_pick2 = 1'b0;
         end else if (sec_r.fallback_source_field >= tcsf_pkg::TCSF_FBS_LOCAL1) begin
            // codes 5..7 become local references 1..3
            next_ctrl.main_source = tcsf_pkg::TCSF_SRC_LOCAL +
               {2'h0, sec_r.fallback_source_field[1:0]};
         end else begin
            // undocumented codes also fall to oscillator over four
            next_ctrl.main_source = tcsf_pkg::TCSF_SRC_OSC;
            next_ctrl.osc_div4_select = 1'b1;
         end
         if (sec_r.fallback_mode_field == tcsf_pkg::TCSF_FB_OSC4) begin
            next_ctrl.main_source = tcsf_pkg::TCSF_SRC_OSC;
            next_ctrl.osc_div4_select = 1'b1;
         end
      end
      next_ctrl.netref_output_enable = netref_r.netref_output_enable;
      next_ctrl.dejitter_bypass = netref_r.dejitter_bypass;
      next_ctrl.netref_invert = netref_r.netref_invert;
      next_ctrl.netref_source = netref_r.netref_source_field;
      next_ctrl.framer_clock_select = prog_r.framer_clock_select;
      next_ctrl.framer_clock_oe_n =
         (prog_r.framer_clock_select == tcsf_pkg::TCSF_FRAMER_HIZ);
      next_ctrl.input_sync_interpretation = prog_r.input_sync_interpretation;
      next_ctrl.pair_a_drive = prog_r.pair_a_output_enable & ~dis_a;
      next_ctrl.pair_b_drive = prog_r.pair_b_output_enable & ~dis_b;
      next_ctrl.bus_clock_rate = prog_r.bus_clock_rate;
      next_ctrl.compat_frame_width = prog_r.compat_frame_width;
      // pll1 input cannot drift: fallback simply swaps the field
      next_ctrl.pll1_input = fb_active ? sec_r.fallback_resource_field
                                       : res_r.pll1_input_field;
      next_ctrl.pll1_bypass = res_r.pll1_bypass;
      next_ctrl.pll1_mult = res_r.pll1_rate ? tcsf_pkg::TCSF_P1_MUL_HI
                                            : tcsf_pkg::TCSF_P1_MUL_LO;
      next_ctrl.pll2_bypass = res_r.pll2_bypass;
      next_ctrl.pll2_mult = res_r.pll2_rate ? tcsf_pkg::TCSF_P2_MUL_HI
                                            : tcsf_pkg::TCSF_P2_MUL_LO;
      next_ctrl.compat_output_rate = res_r.compat_output_rate;
      // compat outputs float when slave or when rate field is 00
      next_ctrl.compat_outputs_oe_n = (res_r.compat_output_rate == tcsf_pkg::TCSF_COMPAT_HIZ) |
                                      ~next_ctrl.compat_master;
      next_ctrl.fallback_active = fb_active;
   end

   // every control output leaves from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // checks on the register bus and the clock controls
   AST_WRITE_MAIN: assert property (@(posedge pclk) disable iff (!presetn)
      wr_en && idx == tcsf_pkg::TCSF_IDX_MAIN |=> main_r == $past(wbyte))
      else $error("main register write not stored");

   AST_INVERT_FOLLOWS: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ctrl.selector_invert == $past(main_r.selector_invert))
      else $error("selector invert not one cycle after register");

   AST_FORCE_FALLBACK: assert property (@(posedge pclk) disable iff (!presetn)
      sec_r.force_fallback |=> ctrl.fallback_active)
      else $error("forced fallback not active next cycle");

   AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
      fb_state == tcsf_pkg::TCSF_FALLEN && !(wr_en && idx == tcsf_pkg::TCSF_IDX_SEC)
      |=> fb_state == tcsf_pkg::TCSF_FALLEN)
      else $error("fallback left without software re-arm");

   AST_MODE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      fb_state == tcsf_pkg::TCSF_NORMAL &&
      sec_r.fallback_mode_field == tcsf_pkg::TCSF_FB_OFF
      |=> fb_state == tcsf_pkg::TCSF_NORMAL)
      else $error("fallback entered while disabled");

   AST_LOCAL_NO_TRIGGER: assert property (@(posedge pclk) disable iff (!presetn)
      fb_state == tcsf_pkg::TCSF_NORMAL && main_r.main_source_field[3] &&
      sec_r.fallback_mode_field == tcsf_pkg::TCSF_FB_GENERAL
      |=> fb_state == tcsf_pkg::TCSF_NORMAL)
      else $error("local reference selection caused fallback");

   AST_PLL1_SELECT: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ctrl.pll1_input == ($past(fb_active) ? $past(sec_r.fallback_resource_field)
                                                     : $past(res_r.pll1_input_field)))
      else $error("pll1 input not taken from the right field");

   // a rewrite in the cycle after the failure may turn the pair back on
   AST_PAIR_A_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      clock_fail[tcsf_pkg::TCSF_F_A] && !(wr_en && idx == tcsf_pkg::TCSF_IDX_PROG)
      ##1 !(wr_en && idx == tcsf_pkg::TCSF_IDX_PROG)
      |=> !ctrl.pair_a_drive)
      else $error("pair a still driven after its failure");

   // enable follows the stored select one cycle later
   AST_FRAMER_HIZ: assert property (@(posedge pclk) disable iff (!presetn)
      1'b1 |=> ctrl.framer_clock_oe_n ==
         ($past(prog_r.framer_clock_select) == tcsf_pkg::TCSF_FRAMER_HIZ))
      else $error("framer clock enable disagrees with select");

   AST_PLL1_MULT: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(res_r.pll1_rate) |=> ctrl.pll1_mult == tcsf_pkg::TCSF_P1_MUL_HI)
      else $error("pll1 multiplier not 32 after rate bit set");

   // one access cycle, no wait states
   AST_APB_READY: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready)
      else $error("pready not raised after setup");

   // unmapped words answer with an error
   AST_APB_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access without error");

   // no write, no change
   AST_MAIN_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_en && idx == tcsf_pkg::TCSF_IDX_MAIN) |=> $stable(main_r))
      else $error("main register changed without a write");

   // mode 00 always lands on the oscillator over four
   AST_OSC4_MODE: assert property (@(posedge pclk) disable iff (!presetn)
      fb_active && sec_r.fallback_mode_field == tcsf_pkg::TCSF_FB_OSC4
      |=> ctrl.osc_div4_select && ctrl.main_source == tcsf_pkg::TCSF_SRC_OSC)
      else $error("mode 00 fallback not on oscillator");

   // pair b mirrors pair a
   AST_PAIR_B_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      clock_fail[tcsf_pkg::TCSF_F_B] && !(wr_en && idx == tcsf_pkg::TCSF_IDX_PROG)
      ##1 !(wr_en && idx == tcsf_pkg::TCSF_IDX_PROG)
      |=> !ctrl.pair_b_drive)
      else $error("pair b still driven after its failure");

   // rate field 00 floats the compat outputs
   AST_COMPAT_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
      res_r.compat_output_rate == tcsf_pkg::TCSF_COMPAT_HIZ |=> ctrl.compat_outputs_oe_n)
      else $error("compat outputs driven with rate field 00");
endmodule

/* File: bench/tcsf_fail_model.sv */
`timescale 1ns/1ps
// far-side boards: a board that dies stops its clock and the watchdog flags it
module tcsf_fail_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [tcsf_pkg::TCSF_FAIL_W-1:0] kill, // commanded board failures
   output logic [tcsf_pkg::TCSF_FAIL_W-1:0] clock_fail
);
   // flags trail the failure by one edge, as a real watchdog would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_fail <= '0;
      end else begin
         clock_fail <= kill;
      end
   end
endmodule

/* File: bench/test_tcsf_clock_regs.sv */
`timescale 1ns/1ps
module test_tcsf_clock_regs;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [5:0] kill = 6'h00; // failures commanded to the far side
   logic [5:0] clock_fail;
   tcsf_pkg::tcsf_ctrl_s ctrl;
   logic [31:0] rdat; // last read data
   logic rerr; // last error flag
   logic [7:0] mv [3] = '{8'hd5, 8'h2a, 8'h0f}; // main values, both directions
   logic [7:0] main_view;
   logic [7:0] netref_view;
   logic [7:0] prog_view;
   int bad_count = 0;
   int tests_run = 0;
   // regrouped ctrl fields so one compare covers a whole register
   assign main_view = {ctrl.phase_align_enable, ctrl.phase_align_style,
      ctrl.compat_master, ctrl.selector_invert, ctrl.main_source};
   assign netref_view = {ctrl.netref_output_enable, ctrl.dejitter_bypass,
      ctrl.netref_invert, ctrl.netref_source};
   assign prog_view = {ctrl.framer_clock_select, ctrl.input_sync_interpretation,
      ctrl.pair_a_drive, ctrl.pair_b_drive, ctrl.bus_clock_rate, ctrl.compat_frame_width};
   // 20 MHz clock
   always #25 pclk = ~pclk;
   tcsf_clock_regs u_tcsf_clock_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_fail(clock_fail),
      .ctrl(ctrl));
   tcsf_fail_model u_tcsf_fail_model (.pclk(pclk), .presetn(presetn), .kill(kill),
      .clock_fail(clock_fail));
   // byte address of a register word
   function automatic logic [7:0] ad(input logic [2:0] i);
      return {3'h0, i, 2'h0};
   endfunction
   // compare and count
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one apb transfer; a dead slave is left to the watchdog
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      check(rdat, {24'h0, e});
   endtask
   // let ctrl catch up, then sample away from the rising edge
   task automatic look;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      #100000;
      bad_count++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) rd(ad(i[2:0]), 8'h00);
      look;
      check(ctrl.framer_clock_oe_n, 1'b1);
      foreach (mv[k]) begin
         apb(1'b1, ad(tcsf_pkg::TCSF_IDX_MAIN), mv[k]);
         look;
         check(main_view, mv[k]);
         rd(ad(tcsf_pkg::TCSF_IDX_MAIN), mv[k]);
      end
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_CTRL), 8'h30);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_NETREF), 8'h9a);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_PROG), 8'h5f);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_RES), 8'h16);
      look;
      check(ctrl.local_pairs, 1'b1);
      check(netref_view, 8'h9a);
      check(prog_view, 8'h5f);
      check(ctrl.framer_clock_oe_n, 1'b0);
      check({ctrl.pll1_mult, ctrl.pll2_mult}, {6'h20, 6'h10});
      check(ctrl.compat_output_rate, 2'h2);
      check({ctrl.netref_pick2, ctrl.compat_outputs_oe_n}, 2'h3);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_RES), 8'he9);
      look;
      check({ctrl.pll1_input, ctrl.pll1_bypass, ctrl.pll2_bypass}, 4'hf);
      check({ctrl.pll1_mult, ctrl.pll2_mult}, {6'h10, 6'h08});
      rd(ad(tcsf_pkg::TCSF_IDX_RES), 8'he9);
      apb(1'b0, 8'h20, 8'h00);
      check(rerr, 1'b1);
      // general mode on pair A; mask before secondary, as software must
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_MAIN), 8'h02);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_MASK), 8'h3f);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h60);
      look;
      check(ctrl.fallback_active, 1'b0);
      @(posedge pclk);
      kill <= 6'h02;
      look;
      check(ctrl.fallback_active, 1'b1);
      check({ctrl.pll1_input, ctrl.osc_div4_select}, 3'h3);
      check({ctrl.pair_a_drive, ctrl.pair_b_drive}, 2'h1);
      @(posedge pclk);
      kill <= 6'h3f;
      look;
      check(ctrl.fallback_active, 1'b1);
      // disabled mode ignores failures, force still works
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h10);
      look;
      check(ctrl.fallback_active, 1'b0);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h18);
      look;
      check(ctrl.fallback_active, 1'b1);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h10);
      look;
      check(ctrl.fallback_active, 1'b0);
      // mode 00 falls on the pair A failure, always to oscillator over four
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h01);
      look;
      check({ctrl.fallback_active, ctrl.main_source, ctrl.osc_div4_select}, 6'h21);
      rd(ad(tcsf_pkg::TCSF_IDX_STATUS), 8'h07);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h1d);
      look;
      check({ctrl.main_source, ctrl.osc_div4_select}, 5'h12);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h1c);
      look;
      check({ctrl.main_source, ctrl.netref_pick2}, 5'h02);
      // local selection never triggers in general mode
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_MAIN), 8'h08);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h20);
      look;
      check(ctrl.fallback_active, 1'b0);
      // bus mode: slave on pair A takes over the compat clocks
      @(posedge pclk);
      kill <= 6'h00;
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_MAIN), 8'h02);
      apb(1'b1, ad(tcsf_pkg::TCSF_IDX_SEC), 8'h30);
      @(posedge pclk);
      kill <= 6'h02;
      look;
      check({ctrl.fallback_active, ctrl.compat_master}, 2'h3);
      check(ctrl.compat_outputs_oe_n, 1'b0);
      report_and_stop;
   end
endmodule
